// ---- sensor_bank_pkg.sv ----
package sensor_bank_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_BANDING = 8'h0C;
  localparam logic [7:0] OFS_HOLD = 8'h0D;
  localparam logic [7:0] OFS_EXPO = 8'h10;
  localparam logic [7:0] OFS_CLKRATE = 8'h11;
  localparam logic [7:0] OFS_MODE = 8'h12;
  localparam logic [7:0] OFS_AUTO = 8'h13;
  localparam logic [7:0] OFS_GAIN = 8'h14;
  localparam logic [7:0] OFS_TIMING = 8'h15;
  localparam logic [7:0] OFS_HST = 8'h17;
  localparam logic [7:0] OFS_HEND = 8'h18;
  localparam logic [7:0] OFS_VST = 8'h19;
  localparam logic [7:0] OFS_VWIN_END = 8'h1A;
  localparam logic [7:0] OFS_MAKER_HI = 8'h1C;
  localparam logic [7:0] OFS_MAKER_LO = 8'h1D;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_BANDING = 8'h38;
  localparam logic [7:0] RST_HOLD = 8'h07;
  localparam logic [7:0] RST_EXPO = 8'h33;
  localparam logic [7:0] RST_CLKRATE = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_AUTO = 8'hC7;
  localparam logic [7:0] RST_GAIN = 8'h50;
  localparam logic [7:0] RST_TIMING = 8'h00;
  localparam logic [7:0] RST_HST = 8'h11;
  localparam logic [7:0] RST_HEND = 8'h75;
  localparam logic [7:0] RST_VST = 8'h01;
  localparam logic [7:0] RST_VWIN_END = 8'h97;
  // arbitrary neutral maker code
  localparam logic [7:0] MAKER_HI = 8'h5A;
  localparam logic [7:0] MAKER_LO = 8'h3C;
  // value read at reserved locations
  localparam logic [7:0] RSVD_READ = 8'h00;
  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_BAND_50 = 2;
  localparam int BIT_BAND_AUTO = 1;
  localparam int BIT_SNAP_SINGLE = 0;
  localparam int BIT_HOLD_PINS = 2;
  localparam int BIT_DOUBLER = 7;
  localparam int DIV_MSB = 5;
  localparam int BIT_SOFT_RESET = 7;
  localparam int RES_MSB = 6;
  localparam int RES_LSB = 4;
  localparam int BIT_COLORBAR = 1;
  localparam int BIT_BANDFILT = 5;
  localparam int BIT_AGC_AUTO = 2;
  localparam int BIT_EXPO_AUTO = 0;
  localparam int CEIL_MSB = 7;
  localparam int CEIL_LSB = 5;
  localparam int BIT_SWAP_A = 7;
  localparam int BIT_SWAP_B = 6;
  localparam int BIT_PCLK_GATE = 5;
  localparam int BIT_PCLK_EDGE = 4;
  localparam int BIT_LV_NEG = 3;
  localparam int BIT_VS_NEG = 1;
  localparam int BIT_HS_NEG = 0;
  // ****************************************
  // encodings
  // ****************************************
  localparam logic [2:0] RES_UXGA = 3'h0;
  localparam logic [2:0] RES_CIF = 3'h1;
  localparam logic [2:0] RES_SVGA = 3'h4;
  localparam logic [7:0] CEIL_MAX_GAIN = 8'h80;
  localparam int BAND_MIN_HZ = 120;
endpackage

// ---- sensor_control_register_bank.sv ----
`timescale 1ns/1ps
// Behaviour
// - bit2 picks 50Hz else 60Hz manually
// - bit1 selects automatic banding frequency
// - bit0 single frame versus live after snapshot
// - powerdown pins tristate or hold last
// - exposure is 16 bits from three registers
// - exposure clamped to one frame period
// - internal clock divided by value plus one
// - bit7 turns doublers on
// - soft reset restores all defaults
// - resolution code UXGA CIF SVGA
// - bit1 enables colour bar pattern
// - banding filter forces 1/120s minimum
// - bit2 automatic versus manual gain
// - bit0 automatic versus manual exposure
// - ceiling code to gain 2x..128x
// - pixel clock gated by line valid
// - data update edge selectable
// - line valid polarity select
// - sync outputs invertible
// - sync pin source swap in bypass
// - horizontal window 11 bits, two pixels
// - vertical window 10 bits, two lines
module sensor_control_register_bank (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // register port, one access per cycle
  input wire logic bank_sensor,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // bits held in other registers
  input wire logic [5:0] exposure_high_bits,
  input wire logic [1:0] exposure_low_bits,
  input wire logic [2:0] hwin_start_low,
  input wire logic [2:0] hwin_end_low,
  input wire logic [1:0] vwin_start_low,
  input wire logic [1:0] vwin_end_low,
  input wire logic [15:0] frame_lines,
  input wire logic bypass_dsp,
  input wire logic band_detect_50,
  // raw timing and data from the array
  input wire logic powerdown,
  input wire logic line_valid_raw,
  input wire logic composite_hsync_raw,
  input wire logic vsync_raw,
  input wire logic hsync_raw,
  input wire logic pixel_clk_raw,
  input wire logic [7:0] pixel_raw,
  // control outputs
  output logic band_50hz,
  output logic band_filter_on,
  output logic [7:0] min_exposure_hz,
  output logic snapshot_single,
  output logic [15:0] exposure_eff,
  output logic [6:0] clk_divisor,
  output logic doubler_on,
  output logic soft_reset_pulse,
  output logic [2:0] resolution,
  output logic color_bar_on,
  output logic gain_auto,
  output logic exposure_auto,
  output logic [7:0] gain_ceiling,
  output logic pclk_update_rising,
  output logic [10:0] hwin_start,
  output logic [10:0] hwin_end,
  output logic [9:0] vwin_start,
  output logic [9:0] vwin_end,
  // pins
  output logic pclk_out,
  output logic sync_pin_a,
  output logic sync_pin_b,
  output logic vsync_out,
  output logic hsync_out,
  output logic [7:0] data_out,
  output logic data_oe_n
);
  // ****************************************
  // reset synchroniser
  // ****************************************
  logic rst_meta_reg;
  logic rst_sync_n_reg;
  // two stage release
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n_reg <= rst_meta_reg;
    end
  end

  // ****************************************
  // register storage
  // ****************************************
  logic [7:0] banding_config_reg;
  logic [7:0] output_hold_config_reg;
  logic [7:0] exposure_mid_reg;
  logic [7:0] clock_rate_config_reg;
  logic [7:0] sensor_mode_config_reg;
  logic [7:0] auto_control_config_reg;
  logic [7:0] gain_limit_config_reg;
  logic [7:0] output_timing_config_reg;
  logic [7:0] hwin_start_high_reg;
  logic [7:0] hwin_end_high_reg;
  logic [7:0] vwin_start_high_reg;
  logic [7:0] vwin_end_high_reg;
  logic soft_reset_reg;
  logic wr_ok;
  // write only when the sensor bank is chosen
  assign wr_ok = reg_wr && bank_sensor;

  // soft reset pulse, one cycle after the write
  always_ff @(posedge clk_sys or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= wr_ok && reg_addr == sensor_bank_pkg::OFS_MODE
        && reg_wdata[sensor_bank_pkg::BIT_SOFT_RESET];
    end
  end

  // register writes; soft reset restores defaults
  always_ff @(posedge clk_sys or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      banding_config_reg <= sensor_bank_pkg::RST_BANDING;
      output_hold_config_reg <= sensor_bank_pkg::RST_HOLD;
      exposure_mid_reg <= sensor_bank_pkg::RST_EXPO;
      clock_rate_config_reg <= sensor_bank_pkg::RST_CLKRATE;
      sensor_mode_config_reg <= sensor_bank_pkg::RST_MODE;
      auto_control_config_reg <= sensor_bank_pkg::RST_AUTO;
      gain_limit_config_reg <= sensor_bank_pkg::RST_GAIN;
      output_timing_config_reg <= sensor_bank_pkg::RST_TIMING;
      hwin_start_high_reg <= sensor_bank_pkg::RST_HST;
      hwin_end_high_reg <= sensor_bank_pkg::RST_HEND;
      vwin_start_high_reg <= sensor_bank_pkg::RST_VST;
      vwin_end_high_reg <= sensor_bank_pkg::RST_VWIN_END;
    end else if (soft_reset_reg) begin
      // every register back to default
      banding_config_reg <= sensor_bank_pkg::RST_BANDING;
      output_hold_config_reg <= sensor_bank_pkg::RST_HOLD;
      exposure_mid_reg <= sensor_bank_pkg::RST_EXPO;
      clock_rate_config_reg <= sensor_bank_pkg::RST_CLKRATE;
      sensor_mode_config_reg <= sensor_bank_pkg::RST_MODE;
      auto_control_config_reg <= sensor_bank_pkg::RST_AUTO;
      gain_limit_config_reg <= sensor_bank_pkg::RST_GAIN;
      output_timing_config_reg <= sensor_bank_pkg::RST_TIMING;
      hwin_start_high_reg <= sensor_bank_pkg::RST_HST;
      hwin_end_high_reg <= sensor_bank_pkg::RST_HEND;
      vwin_start_high_reg <= sensor_bank_pkg::RST_VST;
      vwin_end_high_reg <= sensor_bank_pkg::RST_VWIN_END;
    end else if (wr_ok) begin
      case (reg_addr)
        sensor_bank_pkg::OFS_BANDING: begin
          banding_config_reg <= reg_wdata;
        end
        sensor_bank_pkg::OFS_HOLD: begin
          output_hold_config_reg <= reg_wdata;
        end
        sensor_bank_pkg::OFS_EXPO: begin
          exposure_mid_reg <= reg_wdata;
        end
        sensor_bank_pkg::OFS_CLKRATE: begin
          clock_rate_config_reg <= reg_wdata;
        end
        sensor_bank_pkg::OFS_MODE: begin
          // reset bit self clears
          sensor_mode_config_reg <= {1'b0, reg_wdata[6:0]};
        end
        sensor_bank_pkg::OFS_AUTO: begin
          auto_control_config_reg <= reg_wdata;
        end
        sensor_bank_pkg::OFS_GAIN: begin
          gain_limit_config_reg <= reg_wdata;
        end
        sensor_bank_pkg::OFS_TIMING: begin
          output_timing_config_reg <= reg_wdata;
        end
        sensor_bank_pkg::OFS_HST: begin
          hwin_start_high_reg <= reg_wdata;
        end
        sensor_bank_pkg::OFS_HEND: begin
          hwin_end_high_reg <= reg_wdata;
        end
        sensor_bank_pkg::OFS_VST: begin
          vwin_start_high_reg <= reg_wdata;
        end
        sensor_bank_pkg::OFS_VWIN_END: begin
          vwin_end_high_reg <= reg_wdata;
        end
        // reserved and read-only addresses ignored
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // read path
  // ****************************************
  // registered read data, held between reads
  always_ff @(posedge clk_sys or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && bank_sensor) begin
      case (reg_addr)
        sensor_bank_pkg::OFS_BANDING: reg_rdata <= banding_config_reg;
        sensor_bank_pkg::OFS_HOLD: reg_rdata <= output_hold_config_reg;
        sensor_bank_pkg::OFS_EXPO: reg_rdata <= exposure_mid_reg;
        sensor_bank_pkg::OFS_CLKRATE: reg_rdata <= clock_rate_config_reg;
        sensor_bank_pkg::OFS_MODE: reg_rdata <= sensor_mode_config_reg;
        sensor_bank_pkg::OFS_AUTO: reg_rdata <= auto_control_config_reg;
        sensor_bank_pkg::OFS_GAIN: reg_rdata <= gain_limit_config_reg;
        sensor_bank_pkg::OFS_TIMING: reg_rdata <= output_timing_config_reg;
        sensor_bank_pkg::OFS_HST: reg_rdata <= hwin_start_high_reg;
        sensor_bank_pkg::OFS_HEND: reg_rdata <= hwin_end_high_reg;
        sensor_bank_pkg::OFS_VST: reg_rdata <= vwin_start_high_reg;
        sensor_bank_pkg::OFS_VWIN_END: reg_rdata <= vwin_end_high_reg;
        sensor_bank_pkg::OFS_MAKER_HI: reg_rdata <= sensor_bank_pkg::MAKER_HI;
        sensor_bank_pkg::OFS_MAKER_LO: reg_rdata <= sensor_bank_pkg::MAKER_LO;
        default: reg_rdata <= sensor_bank_pkg::RSVD_READ;
      endcase
    end
  end

  // ****************************************
  // decoded controls
  // ****************************************
  logic [15:0] exposure_prog;
  logic [2:0] ceil_code;
  assign exposure_prog = {exposure_high_bits, exposure_mid_reg, exposure_low_bits};
  assign ceil_code = gain_limit_config_reg[sensor_bank_pkg::CEIL_MSB:sensor_bank_pkg::CEIL_LSB];

  // registered control decode
  always_ff @(posedge clk_sys or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      band_50hz <= 1'b0;
      band_filter_on <= 1'b0;
      min_exposure_hz <= 8'h00;
      snapshot_single <= 1'b0;
      exposure_eff <= 16'h0000;
      clk_divisor <= 7'h01;
      doubler_on <= 1'b0;
      resolution <= 3'h0;
      color_bar_on <= 1'b0;
      gain_auto <= 1'b0;
      exposure_auto <= 1'b0;
      gain_ceiling <= 8'h02;
      pclk_update_rising <= 1'b0;
      hwin_start <= 11'h000;
      hwin_end <= 11'h000;
      vwin_start <= 10'h000;
      vwin_end <= 10'h000;
    end else begin
      // auto detect overrides manual choice
      band_50hz <= banding_config_reg[sensor_bank_pkg::BIT_BAND_AUTO] ? band_detect_50
        : banding_config_reg[sensor_bank_pkg::BIT_BAND_50];
      band_filter_on <= auto_control_config_reg[sensor_bank_pkg::BIT_BANDFILT];
      min_exposure_hz <= auto_control_config_reg[sensor_bank_pkg::BIT_BANDFILT]
        ? 8'(sensor_bank_pkg::BAND_MIN_HZ) : 8'h00;
      snapshot_single <= banding_config_reg[sensor_bank_pkg::BIT_SNAP_SINGLE];
      // clamp to frame length
      exposure_eff <= (exposure_prog > frame_lines) ? frame_lines : exposure_prog;
      clk_divisor <= {1'b0, clock_rate_config_reg[sensor_bank_pkg::DIV_MSB:0]} + 7'h01;
      doubler_on <= clock_rate_config_reg[sensor_bank_pkg::BIT_DOUBLER];
      resolution <= sensor_mode_config_reg[sensor_bank_pkg::RES_MSB:sensor_bank_pkg::RES_LSB];
      color_bar_on <= sensor_mode_config_reg[sensor_bank_pkg::BIT_COLORBAR];
      gain_auto <= auto_control_config_reg[sensor_bank_pkg::BIT_AGC_AUTO];
      exposure_auto <= auto_control_config_reg[sensor_bank_pkg::BIT_EXPO_AUTO];
      // 2x shifted by code, top two codes 128x
      gain_ceiling <= (ceil_code[2] && ceil_code[1]) ? sensor_bank_pkg::CEIL_MAX_GAIN
        : 8'(8'h02 << ceil_code);
      pclk_update_rising <= output_timing_config_reg[sensor_bank_pkg::BIT_PCLK_EDGE];
      hwin_start <= {hwin_start_high_reg, hwin_start_low};
      hwin_end <= {hwin_end_high_reg, hwin_end_low};
      vwin_start <= {vwin_start_high_reg, vwin_start_low};
      vwin_end <= {vwin_end_high_reg, vwin_end_low};
    end
  end
  assign soft_reset_pulse = soft_reset_reg;

  // ****************************************
  // output pins
  // ****************************************
  logic lv_pol;
  assign lv_pol = line_valid_raw ^ output_timing_config_reg[sensor_bank_pkg::BIT_LV_NEG];

  // sync pins registered
  always_ff @(posedge clk_sys or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      sync_pin_a <= 1'b0;
      sync_pin_b <= 1'b0;
      vsync_out <= 1'b0;
      hsync_out <= 1'b0;
      pclk_out <= 1'b0;
    end else begin
      // swap only when processor bypassed
      sync_pin_a <= (bypass_dsp && output_timing_config_reg[sensor_bank_pkg::BIT_SWAP_A])
        ? lv_pol : composite_hsync_raw;
      sync_pin_b <= (bypass_dsp && output_timing_config_reg[sensor_bank_pkg::BIT_SWAP_B])
        ? composite_hsync_raw : lv_pol;
      vsync_out <= vsync_raw ^ output_timing_config_reg[sensor_bank_pkg::BIT_VS_NEG];
      hsync_out <= hsync_raw ^ output_timing_config_reg[sensor_bank_pkg::BIT_HS_NEG];
      // gated clock follows line valid
      pclk_out <= pixel_clk_raw && (!output_timing_config_reg[sensor_bank_pkg::BIT_PCLK_GATE]
        || line_valid_raw);
    end
  end

  // data pins: hold or release in power-down
  always_ff @(posedge clk_sys or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      data_out <= 8'h00;
      data_oe_n <= 1'b1;
    end else if (powerdown) begin
      data_oe_n <= !output_hold_config_reg[sensor_bank_pkg::BIT_HOLD_PINS];
    end else begin
      data_out <= pixel_raw;
      data_oe_n <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence soft_reset_write_s;
    wr_ok && reg_addr == sensor_bank_pkg::OFS_MODE && reg_wdata[sensor_bank_pkg::BIT_SOFT_RESET];
  endsequence
  sequence defaults_s;
    auto_control_config_reg == sensor_bank_pkg::RST_AUTO && hwin_end_high_reg == sensor_bank_pkg::RST_HEND;
  endsequence
  chk_soft_reset_defaults: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_reg)
    soft_reset_write_s |=> soft_reset_reg ##1 defaults_s) else $error("soft reset did not restore defaults");
  chk_exposure_clamp: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_reg)
    ##1 exposure_eff <= $past(frame_lines)) else $error("exposure exceeds frame");
  chk_divisor_value: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_reg)
    ##1 clk_divisor == {1'b0, $past(clock_rate_config_reg[5:0])} + 7'h01) else $error("divisor wrong");
  chk_gain_ceiling_top: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_reg)
    ceil_code[2:1] == 2'b11 |=> gain_ceiling == 8'h80) else $error("ceiling not 128x");
  chk_gain_ceiling_low: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_reg)
    ceil_code == 3'h0 |=> gain_ceiling == 8'h02) else $error("ceiling not 2x");
  chk_powerdown_tristate: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_reg)
    powerdown && !output_hold_config_reg[2] |=> data_oe_n) else $error("pins driven in power-down");
  chk_powerdown_hold: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_reg)
    powerdown && output_hold_config_reg[2] |=> !data_oe_n && $stable(data_out)) else $error("hold lost");
  chk_band_manual: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_reg)
    !banding_config_reg[1] |=> band_50hz == $past(banding_config_reg[2])) else $error("banding select wrong");
  chk_pclk_gated: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_reg)
    output_timing_config_reg[5] && !line_valid_raw |=> !pclk_out) else $error("pixel clock not gated");
  chk_reserved_read: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_reg)
    reg_rd && bank_sensor && reg_addr == 8'h16 |=> reg_rdata == 8'h00) else $error("reserved read not zero");
  chk_vsync_invert: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_reg)
    ##1 vsync_out == ($past(vsync_raw) ^ $past(output_timing_config_reg[1]))) else $error("vsync polarity");
  // antecedents gated by the synced reset so the release edge is skipped
  chk_drive_normal: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_reg)
    rst_sync_n_reg && !powerdown |=> !data_oe_n && data_out == $past(pixel_raw)) else $error("pins not driven");
  chk_gain_mode: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_reg)
    rst_sync_n_reg |=> gain_auto == $past(auto_control_config_reg[2])) else $error("gain mode wrong");
  chk_lv_polarity: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_reg)
    rst_sync_n_reg && !bypass_dsp |=> sync_pin_b == ($past(line_valid_raw) ^ $past(output_timing_config_reg[3])))
    else $error("line valid polarity");
  chk_bank_refused: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_reg)
    reg_wr && !bank_sensor && !soft_reset_reg |=> $stable(banding_config_reg)) else $error("other bank write landed");
  chk_reserved_write: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_reg)
    wr_ok && reg_addr == 8'h16 && !soft_reset_reg |=> $stable(output_timing_config_reg))
    else $error("reserved write changed state");
endmodule

// ---- sensor_host_model.sv ----
`timescale 1ns/1ps
// ****************************************
// host side of the register port
// ****************************************
module sensor_host_model (
  // clock
  input wire logic clk_sys,
  // register port
  output logic bank_sensor,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // idle port, sensor bank already chosen
  initial begin
    bank_sensor = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // one access, held up to its taking edge
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic bank,
                     output logic [7:0] q);
    @(posedge clk_sys);
    #2;
    bank_sensor = bank;
    reg_wr = wr;
    reg_rd = ~wr;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk_sys);
    #2;
    q = reg_rdata;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    bank_sensor = 1'b1;
    // released bus shows no stale value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule

// ---- sensor_control_register_bank_bench.sv ----
`timescale 1ns/1ps
// ****************************************
// bench top
// ****************************************
module sensor_control_register_bank_bench;
  logic clk_sys, reset_n, bank_sensor, reg_wr, reg_rd, bypass_dsp, band_detect_50, powerdown;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pixel_raw, min_exposure_hz, gain_ceiling, data_out, q;
  logic [5:0] exposure_high_bits;
  logic [1:0] exposure_low_bits, vwin_start_low, vwin_end_low;
  logic [2:0] hwin_start_low, hwin_end_low, resolution;
  logic [15:0] frame_lines, exposure_eff;
  logic line_valid_raw, composite_hsync_raw, vsync_raw, hsync_raw, pixel_clk_raw, lv;
  logic band_50hz, band_filter_on, snapshot_single, doubler_on, soft_reset_pulse, color_bar_on;
  logic gain_auto, exposure_auto, pclk_update_rising, pclk_out, sync_pin_a, sync_pin_b;
  logic vsync_out, hsync_out, data_oe_n;
  logic [6:0] clk_divisor;
  logic [10:0] hwin_start, hwin_end;
  logic [9:0] vwin_start, vwin_end;
  integer fail_count, checks_done, seed, pulses;
  // writable registers, defined-bit masks
  logic [7:0] offs [12] = '{8'h0C, 8'h0D, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h17, 8'h18, 8'h19, 8'h1A};
  logic [7:0] msk [12] = '{8'h07, 8'h04, 8'hFF, 8'hBF, 8'h76, 8'h25, 8'hE0, 8'hFB, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] dflt [12] = '{sensor_bank_pkg::RST_BANDING, sensor_bank_pkg::RST_HOLD, sensor_bank_pkg::RST_EXPO,
    sensor_bank_pkg::RST_CLKRATE, sensor_bank_pkg::RST_MODE, sensor_bank_pkg::RST_AUTO, sensor_bank_pkg::RST_GAIN,
    sensor_bank_pkg::RST_TIMING, sensor_bank_pkg::RST_HST, sensor_bank_pkg::RST_HEND, sensor_bank_pkg::RST_VST,
    sensor_bank_pkg::RST_VWIN_END};
  logic [7:0] v [12];
  sensor_control_register_bank sensor_control_register_bank_inst (.*);
  sensor_host_model sensor_host_model_inst (.*);
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // soft reset pulse length counter
  always @(posedge clk_sys) begin
    if (soft_reset_pulse === 1'b1) begin
      pulses = pulses + 1;
    end
  end
  // expected values
  function automatic logic [7:0] f_ceil(input logic [2:0] c);
    return (c >= 3'h6) ? 8'h80 : (8'h02 << c);
  endfunction
  function automatic logic [15:0] f_expo(input logic [15:0] e, input logic [15:0] lim);
    return (e > lim) ? lim : e;
  endfunction
  // compare and report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic bank);
    sensor_host_model_inst.acc(1'b1, a, d, bank, q);
  endtask
  task automatic rd(input logic [7:0] a);
    sensor_host_model_inst.acc(1'b0, a, 8'h00, 1'b1, q);
  endtask
  task automatic check_defaults();
    for (int i = 0; i < 12; i++) begin
      rd(offs[i]);
      chk(q & msk[i], dflt[i] & msk[i]);
    end
  endtask
  task automatic end_sim();
    if (fail_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #(20000 * 25);
    fail_count = fail_count + 1;
    end_sim();
  end
  // main sequence
  initial begin
    fail_count = 0;
    checks_done = 0;
    pulses = 0;
    seed = 88;
    {reset_n, bypass_dsp, band_detect_50, powerdown, pixel_raw, frame_lines} = '0;
    {exposure_high_bits, exposure_low_bits, hwin_start_low, hwin_end_low, vwin_start_low, vwin_end_low} = '0;
    {line_valid_raw, composite_hsync_raw, vsync_raw, hsync_raw, pixel_clk_raw} = '0;
    repeat (6) @(posedge clk_sys);
    #2;
    reset_n = 1'b1;
    repeat (5) @(posedge clk_sys);
    check_defaults();
    // maker code, reserved and read-only places, other bank
    rd(8'h1C);
    chk(q, sensor_bank_pkg::MAKER_HI);
    wr(8'h1D, 8'h00, 1'b1);
    rd(8'h1D);
    chk(q, sensor_bank_pkg::MAKER_LO);
    foreach (offs[i]) begin
      wr(8'h16, 8'hFF, 1'b1);
      wr(offs[i], ~dflt[i], 1'b0);
    end
    rd(8'h0E);
    chk(q, sensor_bank_pkg::RSVD_READ);
    rd(8'h16);
    chk(q, sensor_bank_pkg::RSVD_READ);
    check_defaults();
    // random programming
    repeat (20) begin
      foreach (v[i]) v[i] = $random(seed);
      v[4] = (v[4] & 8'h06) | ((({$random(seed)} % 3) == 0) ? 8'h00 : (v[4][0] ? 8'h10 : 8'h40));
      {exposure_high_bits, exposure_low_bits, frame_lines, pixel_raw} = $random(seed);
      {hwin_start_low, hwin_end_low, vwin_start_low, vwin_end_low, bypass_dsp, band_detect_50} = $random(seed);
      {line_valid_raw, composite_hsync_raw, vsync_raw, hsync_raw, pixel_clk_raw} = $random(seed);
      foreach (v[i]) wr(offs[i], v[i], 1'b1);
      foreach (v[i]) begin
        rd(offs[i]);
        chk(q & msk[i], v[i] & msk[i]);
      end
      repeat (3) @(posedge clk_sys);
      #2;
      chk(band_50hz, v[0][1] ? band_detect_50 : v[0][2]);
      chk(snapshot_single, v[0][0]);
      chk(exposure_eff, f_expo({exposure_high_bits, v[2], exposure_low_bits}, frame_lines));
      chk(clk_divisor, {1'b0, v[3][5:0]} + 7'h01);
      chk(doubler_on, v[3][7]);
      chk(resolution, v[4][6:4]);
      chk(color_bar_on, v[4][1]);
      chk({band_filter_on, min_exposure_hz}, v[5][5] ? 9'h178 : 9'h000);
      chk(gain_auto, v[5][2]);
      chk(exposure_auto, v[5][0]);
      chk(gain_ceiling, f_ceil(v[6][7:5]));
      chk(pclk_update_rising, v[7][4]);
      chk({vsync_out, hsync_out}, {vsync_raw ^ v[7][1], hsync_raw ^ v[7][0]});
      lv = line_valid_raw ^ v[7][3];
      if (bypass_dsp) begin
        chk(sync_pin_a, v[7][7] ? lv : composite_hsync_raw);
        chk(sync_pin_b, v[7][6] ? composite_hsync_raw : lv);
      end else begin
        chk(sync_pin_a, composite_hsync_raw);
        chk(sync_pin_b, lv);
      end
      chk(hwin_start, {v[8], hwin_start_low});
      chk(hwin_end, {v[9], hwin_end_low});
      chk({vwin_start, vwin_end}, {v[10], vwin_start_low, v[11], vwin_end_low});
      chk(pclk_out, pixel_clk_raw && (!v[7][5] || line_valid_raw));
      chk({data_oe_n, data_out}, {1'b0, pixel_raw});
      // power-down with new pixel data behind it
      q = pixel_raw;
      powerdown = 1'b1;
      pixel_raw = ~q;
      repeat (3) @(posedge clk_sys);
      #2;
      chk(data_oe_n, !v[1][2]);
      if (v[1][2]) chk(data_out, q);
      powerdown = 1'b0;
    end
    // soft reset
    pulses = 0;
    wr(sensor_bank_pkg::OFS_MODE, 8'h80, 1'b1);
    repeat (3) @(posedge clk_sys);
    #2;
    chk(pulses, 1);
    check_defaults();
    end_sim();
  end
endmodule
